// ### rtl/pixel_input_port.sv
// Purpose: pixel input capture for sd, ed/hd sdr/ddr and ed 54 mhz modes
// Assumes: sys_clk is a 40 MHz system clock; pixel_clock_in, bus and syncs are pins
// Notes: pixel clock is sampled as a level, edges found after synchronising
`timescale 1ns/10ps
`default_nettype none
`include "pix_in_defines.svh"
module pixel_input_port #(
	parameter int BUS_W = 16,
	parameter int SAMPLE_W = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pixel_clock_in,
	input wire logic [BUS_W-1:0] pixel_bus,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic [2:0] input_mode,
	input wire logic [1:0] sd_width_sel,
	input wire logic sd_rgb_input_sel,
	input wire logic hd_ten_bit_sel,
	input wire logic [1:0] luma_edge_sel,
	input wire logic component_space_sel,
	input wire logic sd_composite_out_sel,
	input wire logic sd_y_c_swap,
	input wire logic sd_rgb_reverse,
	input wire logic hd_component_swap,
	output logic [SAMPLE_W-1:0] luma_q,
	output logic [SAMPLE_W-1:0] chroma_q,
	output logic [SAMPLE_W-1:0] red_q,
	output logic [SAMPLE_W-1:0] green_q,
	output logic [SAMPLE_W-1:0] blue_q,
	output logic luma_valid_q,
	output logic chroma_valid_q,
	output logic rgb_valid_q,
	output logic hsync_q,
	output logic vsync_q,
	output logic embedded_timing_q,
	output logic ext_sync_used_q,
	output logic [2:0] mode_q,
	output pix_in_pkg::comp_type dac1_q,
	output pix_in_pkg::comp_type dac2_q,
	output pix_in_pkg::comp_type dac3_q
);
	logic [BUS_W+2:0] pins_s;
	logic pclk_s, pclk_prev_q;
	logic rise, fall;
	logic [BUS_W-1:0] bus_s;
	logic hs_s, vs_s;
	logic phase_q;
	logic [BUS_W-1:0] bus_hold_q;
	pix_in_pkg::fmt_type fmt;
	logic sd_path;
	logic ddr_mode, ed54_mode, sdr_mode;
	logic sd16;
	logic ten_bit;
	logic luma_edge, chroma_edge;
	logic [SAMPLE_W-1:0] word8, word10, word;

	pin_sync #(.WIDTH(BUS_W + 3)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in({pixel_clock_in, hsync_in, vsync_in, pixel_bus}),
		.pin_out(pins_s)
	);
	assign pclk_s = pins_s[BUS_W+2];
	assign hs_s = pins_s[BUS_W+1];
	assign vs_s = pins_s[BUS_W];
	assign bus_s = pins_s[BUS_W-1:0];

	// pixel clock edges seen as transitions of the synchronised level
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pclk_prev_q <= 1'b0;
		end else begin
			pclk_prev_q <= pclk_s;
		end
	end
	assign rise = pclk_s & ~pclk_prev_q;
	assign fall = ~pclk_s & pclk_prev_q;

	// mode register, taken straight from the configuration port
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= `MODE_RESET;
		end else begin
			mode_q <= input_mode;
		end
	end

	always_comb begin
		fmt = pix_in_pkg::FMT_OFF;
		unique case (mode_q)
			`MODE_SD: fmt = pix_in_pkg::FMT_SD;
			`MODE_HD_SDR, `MODE_HD_DDR, `MODE_ED54: fmt = pix_in_pkg::FMT_HD;
			default: fmt = pix_in_pkg::FMT_OFF;
		endcase
	end
	assign sd_path = (fmt == pix_in_pkg::FMT_SD);
	assign sdr_mode = (mode_q == `MODE_HD_SDR);
	assign ddr_mode = (mode_q == `MODE_HD_DDR);
	assign ed54_mode = (mode_q == `MODE_ED54);
	assign sd16 = sd_path & (sd_rgb_input_sel | (sd_width_sel == `SD_W16));
	assign ten_bit = sd_path ? (sd_width_sel == `SD_W10) : hd_ten_bit_sel;
	assign luma_edge = (luma_edge_sel == `LUMA_EDGE_RISE) ? rise : fall;
	assign chroma_edge = (luma_edge_sel == `LUMA_EDGE_RISE) ? fall : rise;

	// unused low bits are masked out rather than passed through
	assign word8 = {bus_s[15:8], 2'h0};
	assign word10 = bus_s[15:6];
	assign word = ten_bit ? word10 : word8;

	// half-rate phase for 16-bit sd: a pixel spans two clocks
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_q <= 1'b0;
			bus_hold_q <= '0;
		end else if (sd16 && rise) begin
			phase_q <= ~phase_q;
			if (!phase_q) begin
				bus_hold_q <= bus_s;
			end
		end else if (!sd16) begin
			phase_q <= 1'b0;
		end
	end

	// luma / interleaved word capture
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			luma_q <= '0;
			luma_valid_q <= 1'b0;
		end else begin
			luma_valid_q <= 1'b0;
			if (sd_path && !sd_rgb_input_sel) begin
				if (sd_width_sel == `SD_W16) begin
					if (rise && phase_q) begin
						luma_q <= {bus_hold_q[15:8], 2'h0};
						luma_valid_q <= 1'b1;
					end
				end else if (rise) begin
					luma_q <= word;
					luma_valid_q <= 1'b1;
				end
			end else if (sdr_mode && rise) begin
				luma_q <= {bus_s[15:8], 2'h0};
				luma_valid_q <= 1'b1;
			end else if (ddr_mode && luma_edge) begin
				luma_q <= word;
				luma_valid_q <= 1'b1;
			end else if (ed54_mode && rise) begin
				luma_q <= word;
				luma_valid_q <= 1'b1;
			end
		end
	end

	// chroma capture; sd 8/10 and 54 MHz carry chroma interleaved in the luma word
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chroma_q <= '0;
			chroma_valid_q <= 1'b0;
		end else begin
			chroma_valid_q <= 1'b0;
			if (sd_path && !sd_rgb_input_sel && sd_width_sel == `SD_W16) begin
				if (rise && phase_q) begin
					chroma_q <= {bus_hold_q[7:0], 2'h0};
					chroma_valid_q <= 1'b1;
				end
			end else if (sdr_mode && rise) begin
				chroma_q <= {bus_s[7:0], 2'h0};
				chroma_valid_q <= 1'b1;
			end else if (ddr_mode && chroma_edge) begin
				chroma_q <= word;
				chroma_valid_q <= 1'b1;
			end
		end
	end

	// rgb 4:4:4 capture, msb-aligned into the sample width
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			red_q <= '0;
			green_q <= '0;
			blue_q <= '0;
			rgb_valid_q <= 1'b0;
		end else begin
			rgb_valid_q <= 1'b0;
			if (sd_path && sd_rgb_input_sel && rise && phase_q) begin
				red_q <= {bus_hold_q[`RED_MSB:`RED_LSB], 5'h00};
				green_q <= {bus_hold_q[`GRN_MSB:`GRN_LSB], 4'h0};
				blue_q <= {bus_hold_q[`BLU_MSB:`BLU_LSB], 5'h00};
				rgb_valid_q <= 1'b1;
			end
		end
	end

	// timing source: embedded codes or external syncs per mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			embedded_timing_q <= 1'b0;
			ext_sync_used_q <= 1'b1;
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end else begin
			embedded_timing_q <= (sd_path && !sd16)
				|| sdr_mode || ddr_mode
				|| ed54_mode;
			// 54 MHz mode takes embedded codes only; syncs are dropped
			ext_sync_used_q <= !ed54_mode && (fmt != pix_in_pkg::FMT_OFF);
			hsync_q <= ed54_mode ? 1'b0 : hs_s;
			vsync_q <= ed54_mode ? 1'b0 : vs_s;
		end
	end

	dac_router u_dac (
		.sys_clk(sys_clk),
		.rst(rst),
		.sd_path(sd_path),
		.component_space_sel(component_space_sel),
		.sd_composite_out_sel(sd_composite_out_sel),
		.sd_y_c_swap(sd_y_c_swap),
		.sd_rgb_reverse(sd_rgb_reverse),
		.hd_component_swap(hd_component_swap),
		.dac1_q(dac1_q),
		.dac2_q(dac2_q),
		.dac3_q(dac3_q)
	);
endmodule
`default_nettype wire

// ### rtl/pix_in_defines.svh
// Purpose: constants for the pixel input port, its checker and its bench
// Assumes: 16-bit pixel bus, 10-bit internal sample width
// Notes: mode codes, width codes and bus field positions
`ifndef PIX_IN_DEFINES_SVH
`define PIX_IN_DEFINES_SVH
`define MODE_SD 3'h0
`define MODE_HD_SDR 3'h1
`define MODE_HD_DDR 3'h2
`define MODE_ED54 3'h7
`define MODE_RESET 3'h0
`define SD_W8 2'h0
`define SD_W16 2'h1
`define SD_W10 2'h2
`define SD_W_RESET 2'h0
`define LUMA_EDGE_RISE 2'h0
`define LUMA_EDGE_RESET 2'h0
`define RED_MSB 4
`define RED_LSB 0
`define GRN_MSB 10
`define GRN_LSB 5
`define BLU_MSB 15
`define BLU_LSB 11
`define CLK_PERIOD_NS 25
`endif

// ### rtl/pix_in_pkg.sv
// Purpose: shared types for the pixel input port
// Assumes: nothing beyond the defines header
// Notes: types only
package pix_in_pkg;
	typedef enum logic [2:0] {
		FMT_SD = 3'b001,
		FMT_HD = 3'b010,
		FMT_OFF = 3'b100
	} fmt_type;
	typedef enum logic [3:0] {
		COMP_GRN = 4'h0,
		COMP_BLU = 4'h1,
		COMP_RED = 4'h2,
		COMP_Y = 4'h3,
		COMP_PB = 4'h4,
		COMP_PR = 4'h5,
		COMP_CVBS = 4'h6,
		COMP_LUMA = 4'h7,
		COMP_CHROMA = 4'h8
	} comp_type;
endpackage

// ### rtl/pin_sync.sv
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage read only by the second
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= '0;
			pin_out <= '0;
		end else begin
			meta_q <= pin_in;
			pin_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### rtl/dac_router.sv
// Purpose: map output component codes onto the three dacs
// Assumes: selects already stable on sys_clk
// Notes: registered, one cycle latency
`timescale 1ns/10ps
`default_nettype none
module dac_router (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sd_path,
	input wire logic component_space_sel,
	input wire logic sd_composite_out_sel,
	input wire logic sd_y_c_swap,
	input wire logic sd_rgb_reverse,
	input wire logic hd_component_swap,
	output pix_in_pkg::comp_type dac1_q,
	output pix_in_pkg::comp_type dac2_q,
	output pix_in_pkg::comp_type dac3_q
);
	pix_in_pkg::comp_type d1_d, d2_d, d3_d;
	always_comb begin
		d1_d = pix_in_pkg::COMP_GRN;
		d2_d = pix_in_pkg::COMP_BLU;
		d3_d = pix_in_pkg::COMP_RED;
		if (sd_path) begin
			if (!component_space_sel) begin
				// reversal swaps red and blue; green stays on dac 1
				if (sd_rgb_reverse) begin
					d2_d = pix_in_pkg::COMP_RED;
					d3_d = pix_in_pkg::COMP_BLU;
				end
			end else if (!sd_composite_out_sel) begin
				d1_d = pix_in_pkg::COMP_Y;
				d2_d = pix_in_pkg::COMP_PB;
				d3_d = pix_in_pkg::COMP_PR;
			end else begin
				d1_d = pix_in_pkg::COMP_CVBS;
				d2_d = sd_y_c_swap ? pix_in_pkg::COMP_CHROMA : pix_in_pkg::COMP_LUMA;
				d3_d = sd_y_c_swap ? pix_in_pkg::COMP_LUMA : pix_in_pkg::COMP_CHROMA;
			end
		end else begin
			if (component_space_sel) begin
				d1_d = pix_in_pkg::COMP_Y;
				d2_d = hd_component_swap ? pix_in_pkg::COMP_PR : pix_in_pkg::COMP_PB;
				d3_d = hd_component_swap ? pix_in_pkg::COMP_PB : pix_in_pkg::COMP_PR;
			end else begin
				d2_d = hd_component_swap ? pix_in_pkg::COMP_RED : pix_in_pkg::COMP_BLU;
				d3_d = hd_component_swap ? pix_in_pkg::COMP_BLU : pix_in_pkg::COMP_RED;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dac1_q <= pix_in_pkg::COMP_GRN;
			dac2_q <= pix_in_pkg::COMP_BLU;
			dac3_q <= pix_in_pkg::COMP_RED;
		end else begin
			dac1_q <= d1_d;
			dac2_q <= d2_d;
			dac3_q <= d3_d;
		end
	end
endmodule
`default_nettype wire

// ### test/pix_src.sv
// Purpose: pixel source model driving clock, bus and syncs
// Assumes: pixel clock toggles every HALF sys_clk cycles while run is high
// Notes: clock stands still when stopped; bus then changes every cycle
`timescale 1ns/10ps
`default_nettype none
module pix_src #(
	parameter int HALF = 4
) (
	input wire logic sys_clk,
	input wire logic run,
	input wire logic [15:0] wr,
	input wire logic [15:0] wf,
	output logic pclk,
	output logic [15:0] bus,
	output logic hs,
	output logic vs
);
	int n = 0;
	initial pclk = 1'b0;
	initial bus = 16'h0000;
	assign hs = run;
	assign vs = run;
	always @(negedge sys_clk) begin
		if (!run) begin
			bus <= ~bus;
		end else if (++n == HALF) begin
			n = 0;
			pclk <= !pclk;
			bus <= pclk ? wf : wr;
		end
	end
endmodule
`default_nettype wire

// ### test/pixel_input_port_sva.sv
// Purpose: port checker for the pixel input port
// Assumes: sees top ports only
// Notes: waits of three cycles cover the config pipeline
`timescale 1ns/10ps
`default_nettype none
`include "pix_in_defines.svh"
module pixel_input_port_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] input_mode,
	input wire logic [1:0] sd_width_sel,
	input wire logic sd_rgb_input_sel,
	input wire logic component_space_sel,
	input wire logic sd_composite_out_sel,
	input wire logic sd_y_c_swap,
	input wire logic hd_component_swap,
	input wire logic luma_valid_q,
	input wire logic hsync_q,
	input wire logic vsync_q,
	input wire logic embedded_timing_q,
	input wire logic ext_sync_used_q,
	input wire logic [2:0] mode_q,
	input wire pix_in_pkg::comp_type dac1_q,
	input wire pix_in_pkg::comp_type dac2_q,
	input wire pix_in_pkg::comp_type dac3_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_rst;
		$fell(rst) |-> mode_q == 3'h0 && ext_sync_used_q && dac1_q == pix_in_pkg::COMP_GRN;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_half;
		mode_q == 3'h0 && sd_width_sel == `SD_W16 && luma_valid_q |=> !luma_valid_q [*4];
	endproperty
	a_half: assert property (p_half) else $error("sd16 samples too close");
	property p_off;
		(mode_q == 3'h3) [*4] |-> !luma_valid_q;
	endproperty
	a_off: assert property (p_off) else $error("capture in off mode");
	property p_ed54;
		(mode_q == 3'h7) [*2] |-> !hsync_q && !vsync_q && !ext_sync_used_q && embedded_timing_q;
	endproperty
	a_ed54: assert property (p_ed54) else $error("ed54 timing source wrong");
	property p_sd16;
		(input_mode == 3'h0 && sd_width_sel == `SD_W16) [*3] |-> !embedded_timing_q;
	endproperty
	a_sd16: assert property (p_sd16) else $error("embedded codes in sd16");
	property p_sd8;
		(input_mode == 3'h0 && sd_width_sel == `SD_W8 && !sd_rgb_input_sel) [*3] |-> embedded_timing_q;
	endproperty
	a_sd8: assert property (p_sd8) else $error("sd8 ignores embedded codes");
	property p_hd_dac;
		(input_mode == 3'h1 && component_space_sel && hd_component_swap) [*3] |->
			dac2_q == pix_in_pkg::COMP_PR && dac3_q == pix_in_pkg::COMP_PB;
	endproperty
	a_hd_dac: assert property (p_hd_dac) else $error("hd swap routing wrong");
	property p_sd_dac;
		(input_mode == 3'h0 && component_space_sel && sd_composite_out_sel && !sd_y_c_swap) [*3]
			|-> dac1_q == pix_in_pkg::COMP_CVBS && dac3_q == pix_in_pkg::COMP_CHROMA;
	endproperty
	a_sd_dac: assert property (p_sd_dac) else $error("sd composite routing wrong");
endmodule
bind pixel_input_port pixel_input_port_sva chk_i (.*);
`default_nettype wire

// ### test/test_pixel_input_port.sv
// Purpose: self-checking bench for the pixel input port
// Assumes: slow pixel clock, one rise every 8 sys_clk cycles
// Notes: pulse counts over 64 cycles expose the capture rate
`timescale 1ns/10ps
`default_nettype none
`include "pix_in_defines.svh"
module test_pixel_input_port;
	logic sys_clk = 0, rst = 1, run = 0, hsync_in, vsync_in, pixel_clock_in;
	logic sd_rgb_input_sel = 0, hd_ten_bit_sel = 0, component_space_sel = 0;
	logic sd_composite_out_sel = 0, sd_y_c_swap = 0, sd_rgb_reverse = 0, hd_component_swap = 0;
	logic [15:0] wr = 0, wf = 0, pixel_bus;
	logic [2:0] input_mode = 0, mode_q;
	logic [1:0] sd_width_sel = 0, luma_edge_sel = 0;
	logic [9:0] luma_q, chroma_q, red_q, green_q, blue_q;
	logic luma_valid_q, chroma_valid_q, rgb_valid_q, hsync_q, vsync_q;
	logic embedded_timing_q, ext_sync_used_q;
	pix_in_pkg::comp_type dac1_q, dac2_q, dac3_q;
	int fails = 0, compares = 0;
	pixel_input_port uut (.*);
	pix_src src (.sys_clk, .run, .wr, .wf, .pclk(pixel_clock_in), .bus(pixel_bus),
		.hs(hsync_in), .vs(vsync_in));
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic wrap_up;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [11:0] e, logic [11:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic [9:0] fld(logic [15:0] w, logic wide);
		return wide ? w[15:6] : {w[15:8], 2'h0};
	endfunction
	function automatic logic [11:0] dx(logic sd, logic c, logic p, logic y, logic v, logic h);
		logic sw;
		sw = sd ? (c ? y : v) : h;
		if (sd && c && p) return sw ? {pix_in_pkg::COMP_CVBS, pix_in_pkg::COMP_CHROMA,
			pix_in_pkg::COMP_LUMA} : {pix_in_pkg::COMP_CVBS, pix_in_pkg::COMP_LUMA,
			pix_in_pkg::COMP_CHROMA};
		if (c) return (sw && !sd) ? {pix_in_pkg::COMP_Y, pix_in_pkg::COMP_PR, pix_in_pkg::COMP_PB}
			: {pix_in_pkg::COMP_Y, pix_in_pkg::COMP_PB, pix_in_pkg::COMP_PR};
		return sw ? {pix_in_pkg::COMP_GRN, pix_in_pkg::COMP_RED, pix_in_pkg::COMP_BLU}
			: {pix_in_pkg::COMP_GRN, pix_in_pkg::COMP_BLU, pix_in_pkg::COMP_RED};
	endfunction
	// em of x skips the timing-source checks
	task automatic tst(logic [2:0] m, logic [1:0] w, logic r, logic t, logic [1:0] e, int n,
		logic em, logic ex);
		logic [9:0] el, ec;
		int k;
		input_mode = m;
		sd_width_sel = w;
		sd_rgb_input_sel = r;
		hd_ten_bit_sel = t;
		luma_edge_sel = e;
		for (int i = 0; i < 3; i++) begin
			wr = $urandom;
			wf = (m == `MODE_HD_DDR) ? 16'($urandom) : wr;
			el = (m == 3'h0 && w == `SD_W10) ? wr[15:6] : m[1] ? fld(e ? wf : wr, t) : fld(wr, 0);
			ec = (m == 3'h2) ? fld(e ? wr : wf, t) : (m == 3'h1 || w == `SD_W16) ? {wr[7:0], 2'h0} : el;
			k = 0;
			repeat (40) @(negedge sys_clk);
			repeat (64) begin
				@(negedge sys_clk);
				if (luma_valid_q | chroma_valid_q | rgb_valid_q) k++;
				if (luma_valid_q) chk("luma", el, luma_q);
				if (chroma_valid_q) chk("chroma", ec, chroma_q);
				if (rgb_valid_q) chk("rgb", {wr[4:0], wr[10:5], wr[15:11]},
					{red_q[9:5], green_q[9:4], blue_q[9:5]});
			end
			chk("pulses", 12'(n), 12'(k));
		end
		if (em !== 1'bx) begin
			chk("embedded", em, embedded_timing_q);
			chk("ext sync", ex, ext_sync_used_q);
			chk("hsync", m != 3'h7, hsync_q);
			chk("vsync", m != 3'h7, vsync_q);
		end
		$display("test mode %h width %h done", m, w);
	endtask
	initial begin
		#200000;
		fails++;
		wrap_up;
	end
	initial begin
		wr = $urandom(42);
		repeat (16) @(negedge sys_clk);
		chk("mode", 0, mode_q);
		chk("dacs", dx(1, 0, 0, 0, 0, 0), {dac1_q, dac2_q, dac3_q});
		rst = 0;
		run = 1;
		tst(3'h0, `SD_W8, 0, 0, 0, 8, 1, 1);
		tst(3'h0, `SD_W10, 0, 0, 0, 8, 1, 1);
		tst(3'h0, `SD_W16, 0, 0, 0, 4, 0, 1);
		tst(3'h0, `SD_W16, 1, 0, 0, 4, 0, 1);
		tst(3'h1, `SD_W8, 0, 1, 0, 8, 1, 1);
		for (int i = 0; i < 4; i++) tst(3'h2, `SD_W8, 0, i[1], {1'b0, i[0]}, 16, 1, 1);
		tst(3'h7, `SD_W8, 0, 0, 0, 8, 1, 0);
		tst(3'h7, `SD_W8, 0, 1, 0, 8, 1, 0);
		tst(3'h3, `SD_W8, 0, 0, 0, 0, 1'bx, 1'bx);
		for (int i = 0; i < 96; i++) begin
			input_mode = (i < 32) ? 3'h0 : (i < 64) ? 3'h1 : 3'h7;
			{component_space_sel, sd_composite_out_sel, sd_y_c_swap, sd_rgb_reverse,
				hd_component_swap} = i[4:0];
			repeat (3) @(negedge sys_clk);
			chk("dacs", dx(i < 32, i[4], i[3], i[2], i[1], i[0]), {dac1_q, dac2_q, dac3_q});
		end
		$display("test dac routing done");
		wrap_up;
	end
endmodule
`default_nettype wire
